// [hdl/fdhp_map.svh]
// Register offsets, field positions, reset values and timing counts of the floppy host port.
// Assumes inclusion by bare name from the design file and the assertion file.
`ifndef FDHP_MAP_SVH
`define FDHP_MAP_SVH
`define FDHP_IDX_DATA       3'h2
`define FDHP_IDX_DRVCTL     3'h2
`define FDHP_IDX_STATUS     3'h4
`define FDHP_IDX_FIFO       3'h5
`define FDHP_IDX_DRATE      3'h7
`define FDHP_IDX_MODE       3'h3
`define FDHP_IDX_SPEC       3'h6
`define FDHP_IDX_CMD        3'h1
`define FDHP_DC_DRV_LO      0
`define FDHP_DC_DRV_HI      1
`define FDHP_DC_GATE        3
`define FDHP_DC_MOTOR0      4
`define FDHP_DC_MOTOR1      5
`define FDHP_DC_RESET       8'h00
`define FDHP_DR_RESET       2'h2
`define FDHP_DR_W           2
`define FDHP_MODE_RESET     8'h00
`define FDHP_SPEC_RESET     8'h00
`define FDHP_FIFO_DEPTH     32
`define FDHP_FIFO_AW        5
`define FDHP_STEP_CYC       16'h0010
`define FDHP_CMD_READ       3'h1
`define FDHP_CMD_WRITE      3'h2
`define FDHP_CMD_STEP_IN    3'h3
`define FDHP_CMD_STEP_OUT   3'h4
`define FDHP_CMD_HEAD       2
`define FDHP_CMD_OP_HI      2
`define FDHP_CMD_LEN_HI     7
`define FDHP_CMD_LEN_LO     3
`endif

// [hdl/fdhp_pkg.sv]
// Types shared by the floppy host port design.
// Assumes fdhp_map.svh is on the include path.
package fdhp_pkg;
  typedef enum logic [2:0] {
    FDHP_IDLE  = 3'b000,
    FDHP_READ  = 3'b001,
    FDHP_WRITE = 3'b010,
    FDHP_STEP  = 3'b011,
    FDHP_DONE  = 3'b100
  } fdhp_state_t;
endpackage

// [hdl/fdhp_top.sv]
// Floppy controller host port: strobed processor bus, DMA handshake, drive pins and a data FIFO.
// Assumes all inputs are synchronous to clk except the drive status inputs, which are synchronised here.
// Notes on behaviour
// - Head select pulled low for head 1, released high for head 0.
// - Low track-zero input means the head sits at the outermost track.
// - Low index input marks the start of each revolution.
// - Reset returns sequencer to idle and all drive outputs inactive.
// - Reset clears the drive control register to zero.
// - Reset loads the data rate register with the lowest rate.
// - Reset keeps specify timing, but returns mode settings to defaults.
// - Data is taken from the bus only during a write strobe.
// - Data bus is driven only during a read strobe.
// - Register strobes count only while chip select is low.
// - Address decodes the register; ignored during DMA cycles.
// - Eight-bit two-way data bus, lower five and upper three bits.
// - DMA request raised only while the gate bit is set.
// - DMA grant answers requests and qualifies strobes only when gated.
// - Terminal count ends DMA, sampled only while grant is low.
// - Interrupt output asserted only while the gate bit is set.
// - Active-low motor enable for drive zero from drive control.
// - Drive select low only when chosen and its motor bit set.
// - Direction low stepping in, high stepping out and during transfers.

module fdhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  // Storage array; no reset so it maps to memory.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

`include "fdhp_map.svh"

module fdhp_top (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Processor bus strobes and address.
  input  wire logic       chip_sel_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] register_index,
  // Host data bus, split into its three signals.
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic      [7:0] host_data_bus_oe,
  // DMA handshake and interrupt.
  output logic            dma_request,
  input  wire logic       dma_grant_n,
  input  wire logic       transfer_end,
  output logic            irq,
  // Drive-side outputs, open drain: oe high pulls the pin low.
  output logic            head_choice_out_oe,
  output logic            step_dir_out_oe,
  output logic            motor_on_drive_zero_n_oe,
  output logic            motor_on_drive_one_n_oe,
  output logic            drive_zero_select_n_oe,
  output logic            drive_one_select_n_oe,
  // Drive-side status inputs, asynchronous.
  input  wire logic       at_outer_track_n,
  input  wire logic       index_n,
  input  wire logic       media_locked_n,
  // Internal observation.
  output logic            index_pulse,
  output logic            write_refused
);
  logic [7:0]             drv_ctl_reg;
  logic [`FDHP_DR_W-1:0]  drate_reg;
  logic [7:0]             mode_reg;
  logic [7:0]             spec_reg;
  logic [7:0]             cmd_reg;
  logic [2:0]             sync_a_reg;
  logic [2:0]             sync_b_reg;
  logic                   index_prev_reg;
  logic                   index_pulse_reg;
  fdhp_pkg::fdhp_state_t  state_reg;
  logic [4:0]             left_reg;
  logic [15:0]            step_cnt_reg;
  logic                   head_reg;
  logic                   dir_in_reg;
  logic                   request_reg;
  logic                   irq_reg;
  logic                   refused_reg;
  logic [7:0]             rdata_reg;
  logic                   rd_prev_reg;
  logic                   wr_prev_reg;
  logic                   gate;
  logic                   dma_cyc;
  logic                   cpu_cyc;
  logic                   rd_strobe;
  logic                   wr_strobe;
  logic                   rd_start;
  logic                   wr_start;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic [7:0]             fifo_in_data;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [7:0]             fifo_out_data;
  logic                   at_track0;
  logic                   locked;
  logic                   end_hit;

  // DMA and interrupt share one gate bit in drive control.
  assign gate      = drv_ctl_reg[`FDHP_DC_GATE];
  assign dma_cyc   = gate && !dma_grant_n;
  assign cpu_cyc   = !chip_sel_n && !dma_cyc;
  assign rd_strobe = !rd_n && (cpu_cyc || dma_cyc);
  assign wr_strobe = !wr_n && (cpu_cyc || dma_cyc);
  assign rd_start  = rd_strobe && !rd_prev_reg;
  assign wr_start  = wr_strobe && !wr_prev_reg;
  assign end_hit   = dma_cyc && transfer_end;
  assign at_track0 = !sync_b_reg[0];
  assign locked    = !sync_b_reg[2];

  // Two-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a_reg <= 3'h7;
      sync_b_reg <= 3'h7;
    end else begin
      sync_a_reg <= {media_locked_n, index_n, at_outer_track_n};
      sync_b_reg <= sync_a_reg;
    end
  end

  // Index edge to one-cycle pulse, once per revolution.
  always_ff @(posedge clk) begin
    if (rst) begin
      index_prev_reg  <= 1'b1;
      index_pulse_reg <= 1'b0;
    end else begin
      index_prev_reg  <= sync_b_reg[1];
      index_pulse_reg <= index_prev_reg && !sync_b_reg[1];
    end
  end
  assign index_pulse = index_pulse_reg;

  // Strobe history, used to take each strobe exactly once.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_strobe;
      wr_prev_reg <= wr_strobe;
    end
  end

  // Host-written registers; specify timing deliberately survives reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      drv_ctl_reg <= `FDHP_DC_RESET;
      drate_reg   <= `FDHP_DR_RESET;
      mode_reg    <= `FDHP_MODE_RESET;
      cmd_reg     <= 8'h00;
    end else if (wr_start && cpu_cyc) begin
      unique case (register_index)
        `FDHP_IDX_DRVCTL: drv_ctl_reg <= host_data_bus_in;
        `FDHP_IDX_DRATE:  drate_reg   <= host_data_bus_in[`FDHP_DR_W-1:0];
        `FDHP_IDX_MODE:   mode_reg    <= host_data_bus_in;
        `FDHP_IDX_CMD:    cmd_reg     <= host_data_bus_in;
        default: ;
      endcase
    end
  end

  // Specify register is loaded but never cleared by reset.
  always_ff @(posedge clk) begin
    if (wr_start && cpu_cyc && register_index == `FDHP_IDX_SPEC) begin
      spec_reg <= host_data_bus_in;
    end
  end

  // Byte sources for the FIFO: DMA or processor writes to the FIFO port while writing.
  assign fifo_in_valid  = wr_start && (state_reg == fdhp_pkg::FDHP_WRITE) &&
                          (dma_cyc || register_index == `FDHP_IDX_FIFO);
  assign fifo_in_data   = host_data_bus_in;
  // Drain side: one byte per index pulse stands in for the bit-serial writer.
  // It keeps draining after terminal count, so bytes already buffered still reach the disk.
  assign fifo_out_ready = (state_reg != fdhp_pkg::FDHP_READ) && index_pulse_reg;

  fdhp_fifo #(
    .WIDTH (8),
    .DEPTH (`FDHP_FIFO_DEPTH),
    .AW    (`FDHP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Sequencer: commands come from the command register write.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= fdhp_pkg::FDHP_IDLE;
      left_reg     <= 5'h00;
      step_cnt_reg <= 16'h0000;
      head_reg     <= 1'b0;
      dir_in_reg   <= 1'b0;
      refused_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        fdhp_pkg::FDHP_IDLE: begin
          if (wr_start && cpu_cyc && register_index == `FDHP_IDX_CMD) begin
            head_reg <= host_data_bus_in[`FDHP_CMD_HEAD];
            left_reg <= host_data_bus_in[`FDHP_CMD_LEN_HI:`FDHP_CMD_LEN_LO];
            unique case (host_data_bus_in[`FDHP_CMD_OP_HI:0])
              `FDHP_CMD_READ:     state_reg <= fdhp_pkg::FDHP_READ;
              `FDHP_CMD_WRITE: begin
                if (locked) begin
                  refused_reg <= 1'b1;
                  state_reg   <= fdhp_pkg::FDHP_DONE;
                end else begin
                  refused_reg <= 1'b0;
                  state_reg   <= fdhp_pkg::FDHP_WRITE;
                end
              end
              `FDHP_CMD_STEP_IN: begin
                dir_in_reg   <= 1'b1;
                step_cnt_reg <= `FDHP_STEP_CYC;
                state_reg    <= fdhp_pkg::FDHP_STEP;
              end
              `FDHP_CMD_STEP_OUT: begin
                dir_in_reg   <= 1'b0;
                step_cnt_reg <= at_track0 ? 16'h0001 : `FDHP_STEP_CYC;
                state_reg    <= fdhp_pkg::FDHP_STEP;
              end
              default: ;
            endcase
          end
        end
        fdhp_pkg::FDHP_READ, fdhp_pkg::FDHP_WRITE: begin
          dir_in_reg <= 1'b0;
          if (end_hit || (rd_start && dma_cyc && left_reg == 5'h00)) begin
            state_reg <= fdhp_pkg::FDHP_DONE;
          end else if (rd_start && dma_cyc) begin
            left_reg <= left_reg - 5'h01;
          end
        end
        fdhp_pkg::FDHP_STEP: begin
          if (step_cnt_reg == 16'h0001) begin
            dir_in_reg <= 1'b0;
            state_reg  <= fdhp_pkg::FDHP_DONE;
          end else begin
            step_cnt_reg <= step_cnt_reg - 16'h0001;
          end
        end
        fdhp_pkg::FDHP_DONE: begin
          // Taken as the status read starts, since a host may drop select and strobe together.
          if (rd_start && cpu_cyc && register_index == `FDHP_IDX_STATUS) begin
            state_reg <= fdhp_pkg::FDHP_IDLE;
          end
        end
        default: state_reg <= fdhp_pkg::FDHP_IDLE;
      endcase
    end
  end
  assign write_refused = refused_reg;

  // DMA request during reads; in writes it follows FIFO room so back-pressure reaches the host.
  always_ff @(posedge clk) begin
    if (rst) begin
      request_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      request_reg <= gate && ((state_reg == fdhp_pkg::FDHP_READ) ||
                     (state_reg == fdhp_pkg::FDHP_WRITE && fifo_in_ready)) && !end_hit;
      irq_reg <= gate && (state_reg == fdhp_pkg::FDHP_DONE);
    end
  end
  assign dma_request = request_reg;
  assign irq         = irq_reg;

  // Read data is latched at strobe start; address is ignored on DMA reads.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_start) begin
      if (dma_cyc) begin
        rdata_reg <= fifo_out_data;
      end else begin
        unique case (register_index)
          `FDHP_IDX_DRVCTL: rdata_reg <= drv_ctl_reg;
          `FDHP_IDX_STATUS: rdata_reg <= {state_reg == fdhp_pkg::FDHP_DONE, refused_reg, fifo_out_valid,
                                         !fifo_in_ready, at_track0, locked, 2'b00};
          `FDHP_IDX_DRATE:  rdata_reg <= {6'h00, drate_reg};
          `FDHP_IDX_MODE:   rdata_reg <= mode_reg;
          `FDHP_IDX_SPEC:   rdata_reg <= spec_reg;
          `FDHP_IDX_CMD:    rdata_reg <= cmd_reg;
          default:          rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // Bus driven only while a qualified read strobe is low, both bit groups together.
  assign host_data_bus_out = rdata_reg;
  assign host_data_bus_oe  = {{3{rd_strobe && rd_prev_reg}}, {5{rd_strobe && rd_prev_reg}}};

  // Drive pins; everything released while in reset or idle defaults.
  assign head_choice_out_oe       = head_reg;
  assign step_dir_out_oe          = dir_in_reg;
  assign motor_on_drive_zero_n_oe = drv_ctl_reg[`FDHP_DC_MOTOR0];
  assign motor_on_drive_one_n_oe  = drv_ctl_reg[`FDHP_DC_MOTOR1];
  assign drive_zero_select_n_oe   = (drv_ctl_reg[`FDHP_DC_DRV_HI:`FDHP_DC_DRV_LO] == 2'h0) &&
                                    drv_ctl_reg[`FDHP_DC_MOTOR0];
  assign drive_one_select_n_oe    = (drv_ctl_reg[`FDHP_DC_DRV_HI:`FDHP_DC_DRV_LO] == 2'h1) &&
                                    drv_ctl_reg[`FDHP_DC_MOTOR1];
endmodule

// [sim/fdhp_host_model.sv]
// Processor and DMA controller model for the bus side of the floppy host port.
// Assumes the bench calls its tasks; every signal changes at the falling clock edge.
module fdhp_host_model (
  // Clock.
  input  wire logic       clk,
  // Strobes, address and data toward the port.
  output logic            chip_sel_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [2:0] register_index,
  output logic      [7:0] host_data_bus_in,
  // Data back from the port.
  input  wire logic [7:0] host_data_bus_out,
  input  wire logic [7:0] host_data_bus_oe,
  // DMA handshake.
  output logic            dma_grant_n,
  output logic            transfer_end
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: strobes, select and grant high, no terminal count.
  initial begin
    {chip_sel_n, rd_n, wr_n, dma_grant_n, transfer_end} = 5'h1E;
    register_index = 3'h0;
    host_data_bus_in = 8'h00;
  end

  // One-cycle write strobe, then one cycle high so strobes never run together.
  task automatic reg_write(input logic sel_n, input logic [2:0] idx, input logic [7:0] data);
    @(negedge clk);
    chip_sel_n = sel_n;
    register_index = idx;
    host_data_bus_in = data;
    wr_n = 1'b0;
    @(negedge clk);
    {chip_sel_n, wr_n} = 2'h3;
    host_data_bus_in = ~data; // A released bus must not keep showing the old byte.
    @(negedge clk);
  endtask

  // Read strobe spans two edges; the byte is taken at the second.
  task automatic reg_read(input logic [2:0] idx, output logic [7:0] data, output logic [7:0] oe);
    @(negedge clk);
    chip_sel_n = 1'b0;
    register_index = idx;
    rd_n = 1'b0;
    repeat (2) @(posedge clk);
    data = host_data_bus_out;
    oe = host_data_bus_oe;
    @(negedge clk);
    {chip_sel_n, rd_n} = 2'h3;
    @(negedge clk);
  endtask

  // DMA byte: select stays high, the grant qualifies the strobe and the address is junk.
  task automatic dma_write(input logic [7:0] data, input logic last);
    @(negedge clk);
    chip_sel_n = 1'b1;
    register_index = ~register_index;
    host_data_bus_in = data;
    transfer_end = last;
    {dma_grant_n, wr_n} = 2'h0;
    @(negedge clk);
    {dma_grant_n, wr_n, transfer_end} = 3'h6;
    host_data_bus_in = ~data;
    @(negedge clk);
  endtask
endmodule

// [sim/fdhp_top_assertions.sv]
// Concurrent checks on the pins of the floppy host port.
// Assumes it is bound to fdhp_top, whose single clock is clk and whose synchronous reset is rst.
`include "fdhp_map.svh"
module fdhp_top_assertions (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Host bus.
  input wire logic       chip_sel_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [2:0] register_index,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic [7:0] host_data_bus_oe,
  // DMA and interrupt.
  input wire logic       dma_request,
  input wire logic       dma_grant_n,
  input wire logic       irq,
  // Drive side.
  input wire logic       head_choice_out_oe,
  input wire logic       step_dir_out_oe,
  input wire logic       motor_on_drive_zero_n_oe,
  input wire logic       motor_on_drive_one_n_oe,
  input wire logic       drive_zero_select_n_oe,
  input wire logic       drive_one_select_n_oe,
  input wire logic       index_n,
  input wire logic       index_pulse
);
  logic [5:0] drv_oe;

  // All drive enables in one vector keeps the reset check short.
  assign drv_oe = {head_choice_out_oe, step_dir_out_oe, motor_on_drive_zero_n_oe,
                   motor_on_drive_one_n_oe, drive_zero_select_n_oe, drive_one_select_n_oe};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The first edge after reset must already see every drive enable, the DMA request, the interrupt and the read data quiet.
  a_reset_quiet: assert property (
    $fell(rst) |-> drv_oe == 6'h00 && !dma_request && !irq && host_data_bus_out == 8'h00)
    else $error("outputs not quiet after reset");
  a_bus_only_read: assert property (
    host_data_bus_oe != 8'h00 |-> !rd_n) else $error("data bus driven without read strobe");
  a_bus_needs_select: assert property (
    host_data_bus_oe != 8'h00 |-> !chip_sel_n || !dma_grant_n) else $error("data bus driven while unselected");
  a_read_drives_bus: assert property (
    (!rd_n && !chip_sel_n) [*2] |-> host_data_bus_oe == 8'hFF) else $error("read did not drive all eight bits");
  a_index_single: assert property (
    index_pulse |=> !index_pulse) else $error("index pulse longer than one cycle");
  a_index_follows: assert property (
    $fell(index_n) |-> ##[2:4] index_pulse) else $error("index edge gave no pulse");
  // A drive select needs its own motor and excludes the other select.
  a_sel_zero_motor: assert property (
    drive_zero_select_n_oe |-> motor_on_drive_zero_n_oe && !drive_one_select_n_oe)
    else $error("drive zero selected without its motor");
  a_sel_one_motor: assert property (
    drive_one_select_n_oe |-> motor_on_drive_one_n_oe && !drive_zero_select_n_oe)
    else $error("drive one selected without its motor");
  a_motor_follows: assert property (
    (!chip_sel_n && !wr_n && register_index == `FDHP_IDX_DRVCTL)
    |=> motor_on_drive_zero_n_oe == $past(host_data_bus_in[4])) else $error("motor zero not taken from write");
endmodule

bind fdhp_top fdhp_top_assertions i_chk (
  .clk(clk), .rst(rst), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n), .register_index(register_index),
  .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
  .dma_request(dma_request), .dma_grant_n(dma_grant_n), .irq(irq), .head_choice_out_oe(head_choice_out_oe),
  .step_dir_out_oe(step_dir_out_oe), .motor_on_drive_zero_n_oe(motor_on_drive_zero_n_oe),
  .motor_on_drive_one_n_oe(motor_on_drive_one_n_oe), .drive_zero_select_n_oe(drive_zero_select_n_oe),
  .drive_one_select_n_oe(drive_one_select_n_oe), .index_n(index_n), .index_pulse(index_pulse)
);

// [sim/test_fdhp_top.sv]
// Self-checking bench for the floppy host port: defaults, drive pins, stepping, refusal, DMA fill and drain.
// Assumes the host model drives the bus side and the bound checker watches the ports.
module test_fdhp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, chip_sel_n, rd_n, wr_n, dma_request, dma_grant_n, transfer_end, irq;
  logic [2:0] register_index;
  logic [7:0] host_data_bus_in, host_data_bus_out, host_data_bus_oe, rd_data, rd_oe;
  logic       head_choice_out_oe, step_dir_out_oe, motor_on_drive_zero_n_oe, motor_on_drive_one_n_oe;
  logic       drive_zero_select_n_oe, drive_one_select_n_oe, index_pulse, write_refused;
  logic       at_outer_track_n, index_n, media_locked_n;
  logic [3:0] drv_oe;
  int         failures, check_count, pulse_count, n;
  // Drive control writes, their select lines, and the motor and select enables each should give.
  logic [7:0] ctl_val [5] = '{8'h10, 8'h10, 8'h01, 8'h21, 8'h20};
  logic [3:0] ctl_exp [5] = '{4'h0, 4'hA, 4'h0, 4'h5, 4'h4};
  logic [4:0] ctl_sel_n   = 5'h01;

  assign drv_oe = {motor_on_drive_zero_n_oe, motor_on_drive_one_n_oe, drive_zero_select_n_oe, drive_one_select_n_oe};

  fdhp_top i_dut (.clk(clk), .rst(rst), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_index(register_index), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .dma_request(dma_request), .dma_grant_n(dma_grant_n),
    .transfer_end(transfer_end), .irq(irq), .head_choice_out_oe(head_choice_out_oe),
    .step_dir_out_oe(step_dir_out_oe), .motor_on_drive_zero_n_oe(motor_on_drive_zero_n_oe),
    .motor_on_drive_one_n_oe(motor_on_drive_one_n_oe), .drive_zero_select_n_oe(drive_zero_select_n_oe),
    .drive_one_select_n_oe(drive_one_select_n_oe), .at_outer_track_n(at_outer_track_n), .index_n(index_n),
    .media_locked_n(media_locked_n), .index_pulse(index_pulse), .write_refused(write_refused));

  fdhp_host_model i_host (.clk(clk), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_index(register_index), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .dma_grant_n(dma_grant_n), .transfer_end(transfer_end));

  // 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counting pulses here catches an index detector that skips or doubles a revolution.
  always @(posedge clk) begin
    if (index_pulse === 1'b1) pulse_count++;
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A wait that ran out of cycles ends the run.
  task automatic give_up(input string name);
    failures++;
    $display("MISMATCH %s expected 1 seen 0", name);
    final_report();
  endtask

  initial begin
    {rst, at_outer_track_n, index_n, media_locked_n} = 4'hF;
    failures = 0;
    check_count = 0;
    pulse_count = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_byte("drive_oe", 8'h00, {2'h0, head_choice_out_oe, step_dir_out_oe, drv_oe});
    check_bit("dma_request", 1'b0, dma_request);
    i_host.reg_read(3'h7, rd_data, rd_oe);
    check_byte("rate", 8'h02, {6'h00, rd_data[1:0]});
    check_byte("read_oe", 8'hFF, rd_oe);
    check_byte("released_oe", 8'h00, host_data_bus_oe);
    $display("test reset_defaults done");
    // A reset in mid-run keeps the specify timing but clears the mode settings.
    i_host.reg_write(1'b0, 3'h6, 8'hA5);
    i_host.reg_write(1'b0, 3'h3, 8'h3C);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    i_host.reg_read(3'h6, rd_data, rd_oe);
    check_byte("specify", 8'hA5, rd_data);
    i_host.reg_read(3'h3, rd_data, rd_oe);
    check_byte("mode", 8'h00, rd_data);
    $display("test second_reset done");
    for (int i = 0; i < 5; i++) begin
      i_host.reg_write(ctl_sel_n[i], 3'h2, ctl_val[i]);
      check_byte("select_motor", {4'h0, ctl_exp[i]}, {4'h0, drv_oe});
    end
    $display("test drive_select done");
    at_outer_track_n = 1'b0;
    i_host.reg_write(1'b0, 3'h2, 8'h10);
    i_host.reg_write(1'b0, 3'h1, 8'h03);
    check_bit("step_in_dir", 1'b1, step_dir_out_oe);
    check_bit("head_zero", 1'b0, head_choice_out_oe);
    repeat (20) @(negedge clk);
    i_host.reg_read(3'h4, rd_data, rd_oe);
    check_bit("step_done", 1'b1, rd_data[7]);
    i_host.reg_write(1'b0, 3'h1, 8'h04);
    check_bit("step_out_dir", 1'b0, step_dir_out_oe);
    check_bit("head_one", 1'b1, head_choice_out_oe);
    repeat (20) @(negedge clk);
    i_host.reg_read(3'h4, rd_data, rd_oe);
    check_bit("track_zero", 1'b1, rd_data[3]);
    $display("test stepping done");
    media_locked_n = 1'b0;
    repeat (2) @(negedge clk);
    i_host.reg_write(1'b0, 3'h1, 8'h02);
    for (n = 0; n < 20 && write_refused !== 1'b1; n++) @(negedge clk);
    if (write_refused !== 1'b1) give_up("write_refused");
    check_bit("irq_gated_off", 1'b0, irq);
    i_host.reg_write(1'b0, 3'h2, 8'h18);
    check_bit("irq_gated_on", 1'b1, irq);
    i_host.reg_read(3'h4, rd_data, rd_oe);
    check_byte("status_refused", 8'hC0, rd_data & 8'hC0);
    check_bit("irq_cleared", 1'b0, irq);
    check_bit("no_request", 1'b0, dma_request);
    $display("test write_protect done");
    // Fill the 32-word buffer by DMA while the index is still, then drain one word per revolution.
    media_locked_n = 1'b1;
    i_host.reg_write(1'b0, 3'h2, 8'h10);
    i_host.reg_write(1'b0, 3'h1, 8'hFA);
    repeat (8) @(negedge clk);
    check_bit("request_gated", 1'b0, dma_request);
    i_host.reg_write(1'b0, 3'h2, 8'h18);
    for (int b = 0; b < 32; b++) begin
      for (n = 0; n < 50 && dma_request !== 1'b1; n++) @(negedge clk);
      if (dma_request !== 1'b1) give_up("dma_request");
      i_host.dma_write(b[7:0], b == 31);
    end
    check_bit("request_after_end", 1'b0, dma_request);
    i_host.reg_read(3'h4, rd_data, rd_oe);
    check_byte("fifo_full", 8'h30, rd_data & 8'h30);
    pulse_count = 0;
    repeat (32) begin
      index_n = 1'b0;
      repeat (4) @(negedge clk);
      index_n = 1'b1;
      repeat (4) @(negedge clk);
    end
    check_byte("index_pulses", 8'h20, pulse_count[7:0]);
    i_host.reg_read(3'h4, rd_data, rd_oe);
    check_byte("fifo_empty", 8'h00, rd_data & 8'h30);
    $display("test dma_fill_drain done");
    final_report();
  end
endmodule
